// ### rtl/phy_cfg_cfg.svh
// Register map, field positions, reset values and timing constants
`ifndef PHY_CFG_CFG_SVH
`define PHY_CFG_CFG_SVH

// Printed register indexes; the byte address is four times the index
`define IDX_CONFIG_THREE 6'h1e
`define IDX_DEVICE_CONTROL 6'h1f
`define IDX_TEST_CHANNEL_CONTROL 6'h25
`define IDX_FAST_DROP_CONFIG 6'h2d
`define APB_ADDR_LSB 2

// config_three fields
`define C3_EXT_FD 11
`define C3_ROBUST_MDIX 9
`define C3_FAST_MDIX 8
`define C3_INT_OE 7
`define C3_FORCE_INT 6
`define C3_CT_FAILED 2
`define C3_CT_COMPLETE 1
`define C3_CT_LAUNCH 0
`define C3_RST 16'h0002

// device_control fields
`define CTL_SOFT_FULL_RESET 15
`define CTL_SOFT_RESTART 14

// test_channel_control fields
`define TC_ALL 7
`define TC_SEL_HI 6
`define TC_SEL_LO 5
`define TC_RSVD_HI 8'h04
`define TC_SEL_RST 3'h0

// fast_drop_config fields
`define FD_ENABLE 15
`define FD_GIGABIT 14
`define FD_STS_HI 12
`define FD_STS_LO 8
`define FD_SRC_HI 4
`define FD_SRC_LO 0
`define FD_NUM 5

// Crossover retry slot times and derived cycle counts
`define CLK_PERIOD_NS 5
`define MDIX_SLOT_NS 62000
`define MDIX_FAST_SLOT_NS 8000
`define MDIX_SLOT_CYC (`MDIX_SLOT_NS / `CLK_PERIOD_NS)
`define MDIX_FAST_SLOT_CYC (`MDIX_FAST_SLOT_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/phy_cfg_pkg.sv
// Types shared by the configuration register block
package phy_cfg_pkg;
	typedef enum logic {
		CT_IDLE,
		CT_RUN
	} cable_test_state_t;

	typedef enum logic [1:0] {
		MDIX_NORMAL,
		MDIX_HUNT,
		MDIX_HELD
	} mdix_state_t;
endpackage

// ### rtl/duplex_mdix_resolver.sv
// Duplex choice and crossover resolution for the copper link
`timescale 1ns/1ps
`include "phy_cfg_cfg.svh"
module duplex_mdix_resolver #(
	parameter int SLOT_CYC = `MDIX_SLOT_CYC,
	parameter int FAST_SLOT_CYC = `MDIX_FAST_SLOT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic ext_fd_en,
	input wire logic robust_en,
	input wire logic fast_en,
	input wire logic local_autoneg,
	input wire logic local_forced_100,
	input wire logic partner_forced_100,
	input wire logic ieee_full_duplex,
	input wire logic mdix_detect_valid,
	input wire logic mdix_detect_cross,
	input wire logic link_up,
	output logic full_duplex,
	output logic mdix_cross
);
	phy_cfg_pkg::mdix_state_t state_q;
	logic [23:0] slot_cnt_q;
	logic [23:0] slot_len;
	logic [7:0] lfsr_q;
	logic cross_q;
	logic duplex_q;
	logic both_forced;
	logic fallback_en;
	logic slot_end;

	// Forced-versus-forced only, local autoneg off: normal detection stalls here
	assign both_forced = local_forced_100 && !local_autoneg && partner_forced_100;
	assign fallback_en = robust_en || (fast_en && both_forced);
	assign slot_len = (fast_en && both_forced) ? 24'(FAST_SLOT_CYC) : 24'(SLOT_CYC);
	assign slot_end = (slot_cnt_q >= slot_len - 24'h000001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duplex_q <= 1'b0;
		end else if (ext_fd_en && partner_forced_100 && (local_autoneg || local_forced_100)) begin
			duplex_q <= 1'b1;
		end else begin
			duplex_q <= ieee_full_duplex;
		end
	end

	// Random bit breaks lockstep when both ends hunt with the same timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_q <= 8'h5a;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= phy_cfg_pkg::MDIX_NORMAL;
			slot_cnt_q <= 24'h000000;
			cross_q <= 1'b0;
		end else if (restart) begin
			state_q <= phy_cfg_pkg::MDIX_NORMAL;
			slot_cnt_q <= 24'h000000;
			cross_q <= 1'b0;
		end else begin
			case (state_q)
				phy_cfg_pkg::MDIX_NORMAL: begin
					slot_cnt_q <= 24'h000000;
					if (mdix_detect_valid) begin
						cross_q <= mdix_detect_cross;
					end else if (fallback_en && !link_up) begin
						state_q <= phy_cfg_pkg::MDIX_HUNT;
					end
				end
				phy_cfg_pkg::MDIX_HUNT: begin
					if (mdix_detect_valid) begin
						cross_q <= mdix_detect_cross;
						state_q <= phy_cfg_pkg::MDIX_NORMAL;
					end else if (link_up) begin
						state_q <= phy_cfg_pkg::MDIX_HELD;
					end else if (!fallback_en) begin
						state_q <= phy_cfg_pkg::MDIX_NORMAL;
					end else if (slot_end) begin
						slot_cnt_q <= 24'h000000;
						if (lfsr_q[0]) begin
							cross_q <= !cross_q;
						end
					end else begin
						slot_cnt_q <= slot_cnt_q + 24'h000001;
					end
				end
				phy_cfg_pkg::MDIX_HELD: begin
					if (!link_up) begin
						slot_cnt_q <= 24'h000000;
						state_q <= phy_cfg_pkg::MDIX_NORMAL;
					end
				end
				default: begin
					state_q <= phy_cfg_pkg::MDIX_NORMAL;
				end
			endcase
		end
	end

	assign full_duplex = duplex_q;
	assign mdix_cross = cross_q;
endmodule

// ### rtl/phy_config_control_regs.sv
// Configuration and control register bank with APB access
`timescale 1ns/1ps
`include "phy_cfg_cfg.svh"
// How it works
// - Extended duplex set, partner forced 100 and local autoneg or forced 100: link runs full duplex.
// - Extended duplex clear: duplex follows standard resolution.
// - Robust crossover resolves where normal detection stalls, without deadlock.
// - Fast crossover shortens resolution when both ends forced 100, no autoneg.
// - Interrupt output enable makes shared pad an interrupt output, else power-down input.
// - Force interrupt bit asserts the interrupt pin regardless of events.
// - Reserved fields ignore writes and read zero, except the test channel upper byte, which reads 0x04.
// - Writing one to cable-test launch starts a measurement; zero does nothing.
// - Cable-test complete resets to one, reads zero while a test runs.
// - Cable-test failed reads one after a failed test, zero otherwise.
// - Soft full reset resets everything including registers, then clears.
// - Soft restart resets the device but keeps registers, then clears.
// - Test channel top bit set drives test mode on all four channels.
// - Top bit clear: two lower bits pick channel A, B, C or D.
// - Fast drop enable turns on fast link drop, off by default.
// - Fast drop gigabit bit selects gigabit fast drop criteria.
// - Five source bits enable each fast drop criterion independently.
// - Status bit latches high when an enabled criterion drops the link.
module phy_config_control_regs #(
	parameter int MDIX_SLOT_CYC = `MDIX_SLOT_CYC,
	parameter int MDIX_FAST_SLOT_CYC = `MDIX_FAST_SLOT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic local_autoneg,
	input wire logic local_forced_100,
	input wire logic partner_forced_100,
	input wire logic ieee_full_duplex,
	input wire logic mdix_detect_valid,
	input wire logic mdix_detect_cross,
	input wire logic link_up,
	output logic full_duplex,
	output logic mdix_cross,
	input wire logic irq_event,
	input wire logic irq_powerdown_pad_i,
	output logic irq_powerdown_pad_o,
	output logic irq_powerdown_pad_oe,
	output logic powerdown_req,
	output logic cable_test_start,
	output logic cable_test_busy,
	input wire logic cable_test_finish,
	input wire logic cable_test_fail,
	output logic device_reset,
	output logic device_restart,
	output logic [3:0] test_channel_drive,
	output logic fast_drop_enable,
	output logic fast_drop_gigabit,
	output logic [`FD_NUM-1:0] fast_drop_criteria,
	input wire logic [`FD_NUM-1:0] fast_drop_cause
);
	// Bus decode
	logic [5:0] idx;
	logic addr_hit;
	logic wr_acc;
	logic rd_acc;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic sel_c3;
	logic sel_ctl;
	logic sel_tc;
	logic sel_fd;

	// Stored fields
	logic ext_fd_q;
	logic robust_q;
	logic fast_mdix_q;
	logic int_oe_q;
	logic force_int_q;
	logic ct_launch_q;
	logic ct_complete_q;
	logic ct_failed_q;
	phy_cfg_pkg::cable_test_state_t ct_state_q;
	logic ct_start_q;
	logic soft_full_reset_q;
	logic soft_restart_q;
	logic [2:0] test_channel_select_q;
	logic fd_enable_q;
	logic fd_gigabit_q;
	logic [`FD_NUM-1:0] fd_src_q;
	logic [`FD_NUM-1:0] fd_sts_q;
	logic [`FD_NUM-1:0] fd_sts_d;
	logic irq_pad_meta_q;
	logic irq_pad_sync_q;
	logic irq_drive_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [15:0] rd_word;

	assign idx = paddr[7:`APB_ADDR_LSB];
	assign sel_c3 = (idx == `IDX_CONFIG_THREE);
	assign sel_ctl = (idx == `IDX_DEVICE_CONTROL);
	assign sel_tc = (idx == `IDX_TEST_CHANNEL_CONTROL);
	assign sel_fd = (idx == `IDX_FAST_DROP_CONFIG);
	assign addr_hit = sel_c3 || sel_ctl || sel_tc || sel_fd;
	// Zero wait states: every access completes in its first access cycle
	assign wr_acc = psel && penable && pwrite && addr_hit;
	assign rd_acc = psel && penable && !pwrite && addr_hit;
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wval = pwdata[15:0];

	// Soft full reset acts one cycle after the write, also clearing itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_full_reset_q <= 1'b0;
		end else if (soft_full_reset_q) begin
			soft_full_reset_q <= 1'b0;
		end else begin
			soft_full_reset_q <= wr_acc && sel_ctl && wmask[`CTL_SOFT_FULL_RESET] && wval[`CTL_SOFT_FULL_RESET];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_restart_q <= 1'b0;
		end else if (soft_full_reset_q || soft_restart_q) begin
			soft_restart_q <= 1'b0;
		end else begin
			soft_restart_q <= wr_acc && sel_ctl && wmask[`CTL_SOFT_RESTART] && wval[`CTL_SOFT_RESTART];
		end
	end

	// config_three control bits; reserved bits have no storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_fd_q <= 1'b0;
			robust_q <= 1'b0;
			fast_mdix_q <= 1'b0;
			int_oe_q <= 1'b0;
			force_int_q <= 1'b0;
			ct_launch_q <= 1'b0;
		end else if (soft_full_reset_q) begin
			ext_fd_q <= 1'b0;
			robust_q <= 1'b0;
			fast_mdix_q <= 1'b0;
			int_oe_q <= 1'b0;
			force_int_q <= 1'b0;
			ct_launch_q <= 1'b0;
		end else if (wr_acc && sel_c3) begin
			if (wmask[`C3_EXT_FD]) begin
				ext_fd_q <= wval[`C3_EXT_FD];
				robust_q <= wval[`C3_ROBUST_MDIX];
				fast_mdix_q <= wval[`C3_FAST_MDIX];
			end
			if (wmask[`C3_INT_OE]) begin
				int_oe_q <= wval[`C3_INT_OE];
				force_int_q <= wval[`C3_FORCE_INT];
				ct_launch_q <= wval[`C3_CT_LAUNCH];
			end
		end
	end

	// Cable test sequencing; a new launch outranks a finish in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_start_q <= 1'b0;
		end else begin
			ct_start_q <= wr_acc && sel_c3 && wmask[`C3_CT_LAUNCH] && wval[`C3_CT_LAUNCH]
				&& !soft_full_reset_q && !soft_restart_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_state_q <= phy_cfg_pkg::CT_IDLE;
			ct_complete_q <= 1'b1;
			ct_failed_q <= 1'b0;
		end else if (soft_full_reset_q || soft_restart_q) begin
			ct_state_q <= phy_cfg_pkg::CT_IDLE;
			ct_complete_q <= 1'b1;
			ct_failed_q <= 1'b0;
		end else begin
			case (ct_state_q)
				phy_cfg_pkg::CT_IDLE: begin
					if (ct_start_q) begin
						ct_state_q <= phy_cfg_pkg::CT_RUN;
						ct_complete_q <= 1'b0;
						ct_failed_q <= 1'b0;
					end
				end
				phy_cfg_pkg::CT_RUN: begin
					if (ct_start_q) begin
						ct_failed_q <= 1'b0;
					end else if (cable_test_finish) begin
						ct_state_q <= phy_cfg_pkg::CT_IDLE;
						ct_complete_q <= 1'b1;
						ct_failed_q <= cable_test_fail;
					end
				end
				default: begin
					ct_state_q <= phy_cfg_pkg::CT_IDLE;
				end
			endcase
		end
	end

	// test_channel_control: only the select field is writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_channel_select_q <= `TC_SEL_RST;
		end else if (soft_full_reset_q) begin
			test_channel_select_q <= `TC_SEL_RST;
		end else if (wr_acc && sel_tc && wmask[`TC_ALL]) begin
			test_channel_select_q <= wval[`TC_ALL:`TC_SEL_LO];
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_chan
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					test_channel_drive[ch] <= 1'b0;
				end else begin
					test_channel_drive[ch] <= test_channel_select_q[2]
						|| (test_channel_select_q[1:0] == 2'(ch));
				end
			end
		end
	endgenerate

	// fast_drop_config controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fd_enable_q <= 1'b0;
			fd_gigabit_q <= 1'b0;
			fd_src_q <= '0;
		end else if (soft_full_reset_q) begin
			fd_enable_q <= 1'b0;
			fd_gigabit_q <= 1'b0;
			fd_src_q <= '0;
		end else if (wr_acc && sel_fd) begin
			if (wmask[`FD_ENABLE]) begin
				fd_enable_q <= wval[`FD_ENABLE];
				fd_gigabit_q <= wval[`FD_GIGABIT];
			end
			if (wmask[`FD_SRC_LO]) begin
				fd_src_q <= wval[`FD_SRC_HI:`FD_SRC_LO];
			end
		end
	end

	// Latched status: a new cause in the read cycle survives the clear
	genvar fb;
	generate
		for (fb = 0; fb < `FD_NUM; fb++) begin : g_fd
			always_comb begin
				fd_sts_d[fb] = fd_sts_q[fb];
				if (rd_acc && sel_fd) begin
					fd_sts_d[fb] = 1'b0;
				end
				if (fd_enable_q && fd_src_q[fb] && fast_drop_cause[fb]) begin
					fd_sts_d[fb] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fd_sts_q <= '0;
		end else if (soft_full_reset_q) begin
			fd_sts_q <= '0;
		end else begin
			fd_sts_q <= fd_sts_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_drop_enable <= 1'b0;
			fast_drop_gigabit <= 1'b0;
			fast_drop_criteria <= '0;
		end else begin
			fast_drop_enable <= fd_enable_q;
			fast_drop_gigabit <= fd_gigabit_q;
			fast_drop_criteria <= fd_enable_q ? fd_src_q : '0;
		end
	end

	// Pad input is asynchronous: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pad_meta_q <= 1'b1;
			irq_pad_sync_q <= 1'b1;
		end else begin
			irq_pad_meta_q <= irq_powerdown_pad_i;
			irq_pad_sync_q <= irq_pad_meta_q;
		end
	end

	// Interrupt is active low on the pad; power-down input is active low too
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_drive_q <= 1'b0;
			powerdown_req <= 1'b0;
		end else begin
			irq_drive_q <= force_int_q || irq_event;
			powerdown_req <= !int_oe_q && !irq_pad_sync_q;
		end
	end

	assign irq_powerdown_pad_oe = int_oe_q;
	assign irq_powerdown_pad_o = !irq_drive_q;

	duplex_mdix_resolver #(
		.SLOT_CYC(MDIX_SLOT_CYC),
		.FAST_SLOT_CYC(MDIX_FAST_SLOT_CYC)
	) u_resolver (
		.pclk(pclk),
		.presetn(presetn),
		.restart(soft_full_reset_q || soft_restart_q),
		.ext_fd_en(ext_fd_q),
		.robust_en(robust_q),
		.fast_en(fast_mdix_q),
		.local_autoneg(local_autoneg),
		.local_forced_100(local_forced_100),
		.partner_forced_100(partner_forced_100),
		.ieee_full_duplex(ieee_full_duplex),
		.mdix_detect_valid(mdix_detect_valid),
		.mdix_detect_cross(mdix_detect_cross),
		.link_up(link_up),
		.full_duplex(full_duplex),
		.mdix_cross(mdix_cross)
	);

	// Read mux; reserved bits read zero apart from the fixed upper byte
	always_comb begin
		rd_word = 16'h0000;
		if (sel_c3) begin
			rd_word[`C3_EXT_FD] = ext_fd_q;
			rd_word[`C3_ROBUST_MDIX] = robust_q;
			rd_word[`C3_FAST_MDIX] = fast_mdix_q;
			rd_word[`C3_INT_OE] = int_oe_q;
			rd_word[`C3_FORCE_INT] = force_int_q;
			rd_word[`C3_CT_FAILED] = ct_failed_q;
			rd_word[`C3_CT_COMPLETE] = ct_complete_q;
			rd_word[`C3_CT_LAUNCH] = ct_launch_q;
		end else if (sel_ctl) begin
			rd_word[`CTL_SOFT_FULL_RESET] = soft_full_reset_q;
			rd_word[`CTL_SOFT_RESTART] = soft_restart_q;
		end else if (sel_tc) begin
			rd_word = {`TC_RSVD_HI, test_channel_select_q, 5'h00};
		end else if (sel_fd) begin
			rd_word[`FD_ENABLE] = fd_enable_q;
			rd_word[`FD_GIGABIT] = fd_gigabit_q;
			rd_word[`FD_STS_HI:`FD_STS_LO] = fd_sts_q;
			rd_word[`FD_SRC_HI:`FD_SRC_LO] = fd_src_q;
		end
	end

	// Read data captured in setup so it stands through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
			pslverr_q <= !addr_hit;
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q && psel && penable;
	assign cable_test_start = ct_start_q;
	assign cable_test_busy = (ct_state_q == phy_cfg_pkg::CT_RUN);
	assign device_reset = soft_full_reset_q;
	assign device_restart = soft_restart_q;
endmodule

// ### tb/cable_test_model.sv
// Behavioural cable-test engine on the far side of the block
`timescale 1ns/1ps
module cable_test_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cable_test_start,
	input wire logic fail_mode,
	input wire logic [7:0] delay_cyc,
	output logic cable_test_finish,
	output logic cable_test_fail
);
	logic [7:0] count_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 8'h0;
			cable_test_finish <= 1'b0;
			cable_test_fail <= 1'b1;
		end else begin
			cable_test_finish <= (count_q == 8'h1);
			// Result line toggles outside finish so a stale value is never seen as valid
			cable_test_fail <= (count_q == 8'h1) ? fail_mode : !cable_test_fail;
			if (cable_test_start) begin
				count_q <= delay_cyc;
			end else if (count_q != 8'h0) begin
				count_q <= count_q - 8'h1;
			end
		end
	end
endmodule

// ### tb/phy_cfg_asserts.sv
// Concurrent checks on the register block ports
`timescale 1ns/1ps
module phy_cfg_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic irq_event,
	input wire logic irq_powerdown_pad_o,
	input wire logic irq_powerdown_pad_oe,
	input wire logic powerdown_req,
	input wire logic cable_test_start,
	input wire logic cable_test_busy,
	input wire logic cable_test_finish,
	input wire logic device_reset,
	input wire logic device_restart,
	input wire logic [3:0] test_channel_drive
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite;
	a_launch_pulse: assert property (wr && paddr == 8'h78 && pstrb[0] && pwdata[0] |=> cable_test_start)
		else $error("cable_test_start missing after launch write");
	a_busy_follows: assert property (cable_test_start |=> cable_test_busy)
		else $error("cable_test_busy not set after start");
	a_finish_idle: assert property (cable_test_busy && cable_test_finish && !cable_test_start |=> !cable_test_busy)
		else $error("cable test still busy after finish");
	a_full_reset: assert property (wr && paddr == 8'h7c && pstrb[1] && pwdata[15] |=> device_reset ##1 !device_reset)
		else $error("device_reset pulse wrong");
	a_restart_pulse: assert property (wr && paddr == 8'h7c && pstrb[1] && pwdata[15:14] == 2'b01
		|=> device_restart ##1 !device_restart)
		else $error("device_restart pulse wrong");
	a_event_drives_pad: assert property (irq_event |=> !irq_powerdown_pad_o)
		else $error("interrupt pad not asserted on event");
	a_pad_role: assert property (powerdown_req |-> !$past(irq_powerdown_pad_oe))
		else $error("power-down request while pad is an output");
	a_channel_drive: assert property ($past(presetn) |-> $onehot(test_channel_drive) || test_channel_drive == 4'hf)
		else $error("test channel drive pattern illegal");
	a_refused_zero: assert property (pslverr |-> psel && penable && prdata == 32'h0)
		else $error("error response outside access or with data");
	c_cable_done: cover property (cable_test_busy && cable_test_finish);
	c_full_reset: cover property (device_reset);
	c_refused: cover property (pslverr);
endmodule

// ### tb/tb.sv
// Directed testbench for the configuration register block
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic local_autoneg = 1'b0, local_forced_100 = 1'b0, partner_forced_100 = 1'b0, ieee_full_duplex = 1'b0;
	logic mdix_detect_valid = 1'b0, mdix_detect_cross = 1'b0, link_up = 1'b1, irq_event = 1'b0;
	logic pd_drv = 1'b1, fail_mode = 1'b0;
	logic [7:0] delay_cyc = 8'h10;
	logic [4:0] fast_drop_cause = 5'h0;
	logic [31:0] prdata;
	logic pready, pslverr, full_duplex, mdix_cross, pad_o, pad_oe, pad_i, powerdown_req;
	logic cable_test_start, cable_test_busy, cable_test_finish, cable_test_fail, device_reset, device_restart;
	logic fast_drop_enable, fast_drop_gigabit;
	logic [3:0] test_channel_drive;
	logic [4:0] fast_drop_criteria;
	int err_count = 0;
	int comparisons = 0;
	assign pad_i = pad_oe ? pad_o : pd_drv;
	always #2.5 pclk = ~pclk;
	phy_config_control_regs #(.MDIX_SLOT_CYC(20), .MDIX_FAST_SLOT_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .local_autoneg(local_autoneg),
		.local_forced_100(local_forced_100), .partner_forced_100(partner_forced_100),
		.ieee_full_duplex(ieee_full_duplex), .mdix_detect_valid(mdix_detect_valid),
		.mdix_detect_cross(mdix_detect_cross), .link_up(link_up), .full_duplex(full_duplex),
		.mdix_cross(mdix_cross), .irq_event(irq_event), .irq_powerdown_pad_i(pad_i),
		.irq_powerdown_pad_o(pad_o), .irq_powerdown_pad_oe(pad_oe), .powerdown_req(powerdown_req),
		.cable_test_start(cable_test_start), .cable_test_busy(cable_test_busy),
		.cable_test_finish(cable_test_finish), .cable_test_fail(cable_test_fail), .device_reset(device_reset),
		.device_restart(device_restart), .test_channel_drive(test_channel_drive),
		.fast_drop_enable(fast_drop_enable), .fast_drop_gigabit(fast_drop_gigabit),
		.fast_drop_criteria(fast_drop_criteria), .fast_drop_cause(fast_drop_cause));
	cable_test_model far_u (.pclk(pclk), .presetn(presetn), .cable_test_start(cable_test_start),
		.fail_mode(fail_mode), .delay_cyc(delay_cyc), .cable_test_finish(cable_test_finish),
		.cable_test_fail(cable_test_fail));
	task conclude;
		$display("Comparisons %0d, errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One idle edge first, so back-to-back calls never assign psel twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'h3;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			err_count++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, d, rd, e);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(name, exp, rd);
	endtask
	task wait_low(input int lim);
		int i;
		for (i = 0; i < lim && (cable_test_busy !== 1'b0 || powerdown_req !== !pd_drv); i++) @(posedge pclk);
		if (i == lim) begin
			err_count++;
			conclude();
		end
	endtask
	task s_reset_values;
		rd_chk(8'h78, 32'h2, "config_three");
		rd_chk(8'h7c, 32'h0, "device_control");
		rd_chk(8'h94, 32'h400, "test_channel_control");
		rd_chk(8'hb4, 32'h0, "fast_drop_config");
		chk("channel_drive", 32'h1, {28'h0, test_channel_drive});
	endtask
	task s_config;
		local_autoneg <= 1'b1;
		partner_forced_100 <= 1'b1;
		mdix_detect_valid <= 1'b1;
		mdix_detect_cross <= 1'b1;
		wr(8'h78, 32'hffff_0ffe);
		rd_chk(8'h78, 32'h0bc2, "config_three");
		chk("full_duplex", 32'h1, {31'h0, full_duplex});
		chk("mdix_cross", 32'h1, {31'h0, mdix_cross});
		chk("pad_oe", 32'h1, {31'h0, pad_oe});
		chk("pad_o", 32'h0, {31'h0, pad_o});
		wr(8'h78, 32'h0);
		pd_drv <= 1'b0;
		rd_chk(8'h78, 32'h2, "config_three");
		chk("full_duplex", 32'h0, {31'h0, full_duplex});
		chk("pad_o", 32'h1, {31'h0, pad_o});
		wait_low(20);
		chk("powerdown_req", 32'h1, {31'h0, powerdown_req});
		irq_event <= 1'b1;
		pd_drv <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("pad_o", 32'h0, {31'h0, pad_o});
		irq_event <= 1'b0;
	endtask
	task s_channels;
		int s;
		for (s = 0; s < 8; s++) begin
			wr(8'h94, {16'hffff, 8'hff, s[2:0], 5'h1f});
			rd_chk(8'h94, {16'h0, 8'h04, s[2:0], 5'h0}, "test_channel_control");
			chk("channel_drive", s[2] ? 32'hf : 32'h1 << s[1:0], {28'h0, test_channel_drive});
		end
	endtask
	task s_fast_drop;
		wr(8'hb4, 32'hffff_dff5);
		rd_chk(8'hb4, 32'hc015, "fast_drop_config");
		chk("fast_drop_flags", 32'h3, {30'h0, fast_drop_enable, fast_drop_gigabit});
		chk("criteria", 32'h15, {27'h0, fast_drop_criteria});
		fast_drop_cause <= 5'h1f;
		@(posedge pclk);
		fast_drop_cause <= 5'h0;
		rd_chk(8'hb4, 32'hd515, "fast_drop_config");
		rd_chk(8'hb4, 32'hc015, "fast_drop_config");
		wr(8'hb4, 32'h1f);
		fast_drop_cause <= 5'h1f;
		@(posedge pclk);
		fast_drop_cause <= 5'h0;
		rd_chk(8'hb4, 32'h1f, "fast_drop_config");
		chk("criteria", 32'h0, {27'h0, fast_drop_criteria});
	endtask
	task s_soft;
		wr(8'hb4, 32'hc015);
		wr(8'h7c, 32'h7fff);
		rd_chk(8'h7c, 32'h0, "device_control");
		rd_chk(8'hb4, 32'hc015, "fast_drop_config");
		wr(8'h7c, 32'h8000);
		rd_chk(8'h7c, 32'h0, "device_control");
		rd_chk(8'hb4, 32'h0, "fast_drop_config");
	endtask
	// Link down with no detector result and robust crossover on, or fast crossover on with both ends forced 100, forces the crossover hunt
	task s_mdix;
		logic c0;
		int i;
		local_autoneg <= 1'b0;
		local_forced_100 <= 1'b1;
		ieee_full_duplex <= 1'b1;
		mdix_detect_valid <= 1'b0;
		link_up <= 1'b0;
		wr(8'h78, 32'h100);
		c0 = mdix_cross;
		for (i = 0; i < 40 && mdix_cross === c0; i++) @(posedge pclk);
		chk("fast_hunt_toggle", 32'h1, {31'h0, i < 40});
		if (i == 40) conclude();
		chk("full_duplex", 32'h1, {31'h0, full_duplex});
		wr(8'h78, 32'h200);
		@(posedge pclk);
		c0 = mdix_cross;
		repeat (14) @(posedge pclk);
		chk("slow_slot_hold", {31'h0, c0}, {31'h0, mdix_cross});
		for (i = 0; i < 1200 && mdix_cross === c0; i++) @(posedge pclk);
		chk("robust_hunt_toggle", 32'h1, {31'h0, i < 1200});
		if (i == 1200) conclude();
		link_up <= 1'b1;
		mdix_detect_valid <= 1'b1;
	endtask
	task s_cable;
		int r;
		for (r = 0; r < 2; r++) begin
			fail_mode <= (r == 0);
			delay_cyc <= (r == 0) ? 8'h40 : 8'h10;
			wr(8'h78, 32'h1);
			rd_chk(8'h78, 32'h1, "config_three");
			wait_low(300);
			rd_chk(8'h78, {29'h0, r == 0, 2'h3}, "config_three");
		end
	endtask
	task s_unmapped;
		logic [31:0] rd;
		logic e;
		apb(1'b0, 8'h80, 32'h0, rd, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		chk("unmapped_data", 32'h0, rd);
		apb(1'b1, 8'h98, 32'hffff, rd, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		s_reset_values;
		s_config;
		s_channels;
		s_fast_drop;
		s_soft;
		s_mdix;
		s_cable;
		s_unmapped;
		conclude();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		err_count++;
		conclude();
	end
endmodule
bind phy_config_control_regs phy_cfg_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pslverr(pslverr), .irq_event(irq_event), .irq_powerdown_pad_o(irq_powerdown_pad_o),
	.irq_powerdown_pad_oe(irq_powerdown_pad_oe), .powerdown_req(powerdown_req),
	.cable_test_start(cable_test_start), .cable_test_busy(cable_test_busy), .cable_test_finish(cable_test_finish),
	.device_reset(device_reset), .device_restart(device_restart), .test_channel_drive(test_channel_drive));
